// >>> src/lpspc_ctrl.sv
//
// Operation
// - without enhanced halt enabled, halt snoops use the plain halt snoop state.
// - in clock-stopped grant or halt, a snoop or interrupt enters the snoop state.
// - the snoop state holds until the snoop is serviced or the interrupt latched.
// - after that the block returns to whichever low-power state it left.
// - with enhanced halt enabled, its snoops use the enhanced halt snoop state.
// - the enhanced halt snoop state keeps the reduced ratio and voltage code.
// - enhanced halt snoops behave as halt snoops and return to enhanced halt.
// - a performance change alters only core ratio and voltage code, never the bus clock.
// - a performance change starts only on a write of the target operating point.
// - going faster, the voltage code steps up first, then the ratio changes.
// - the core ratio never exceeds the rated maximum.
// - going slower, the ratio changes first, then the voltage code steps down.
// - clock-stopped grant starts 20 bus clocks after the acknowledge response.
// - enhanced halt entry lowers ratio then voltage; exit restores voltage then ratio.
// - in clock-stopped grant, interrupts are latched while snoops are processed.
module lpspc_ctrl
    import lpspc_pkg::*;
(
    input  wire logic                       CLOCK,
    input  wire logic                       RST,
    input  wire logic                       EH_ENABLE,
    input  wire logic                       HALT_REQ,
    input  wire logic                       BREAK_EVENT,
    input  wire logic                       STOP_CLOCK_REQUEST_N,
    input  wire logic                       SNOOP_VALID,
    input  wire logic                       SNOOP_DONE,
    input  wire logic                       BUS_INTR,
    input  wire logic                       ACK_RESPONSE,
    input  wire logic                       PS_WRITE,
    input  wire logic [`LPSPC_RATIO_W-1:0]  PS_RATIO,
    input  wire logic [`LPSPC_VID_W-1:0]    PS_VID,
    output logic                            SPECIAL_BUS_CYCLE_REQ,
    output logic                            CORE_CLOCK_RUN,
    output logic                            SNOOP_ACTIVE,
    output logic                            INTR_PENDING,
    output logic      [`LPSPC_RATIO_W-1:0]  CORE_RATIO,
    output logic      [`LPSPC_VID_W-1:0]    VOLTAGE_ID_CODE,
    output logic                            PS_BUSY,
    output logic      [3:0]                 POWER_STATE
);
    typedef struct packed {
        lpspc_state_e                   state_r;
        lpspc_ps_e                      ps_r;
        logic [`LPSPC_RATIO_W-1:0]      ratio_r;
        logic [`LPSPC_RATIO_W-1:0]      op_ratio_r;
        logic [`LPSPC_VID_W-1:0]        op_vid_r;
        logic [`LPSPC_RATIO_W-1:0]      tgt_ratio_r;
        logic [`LPSPC_VID_W-1:0]        vid_tgt_r;
        logic [`LPSPC_GRANT_CNT_W-1:0]  cnt_r;
        logic                           intr_r;
        logic                           intr_ev_r;
        logic                           sbc_r;
    } lpspc_ctrl_s;

    lpspc_ctrl_s st_r;
    lpspc_ctrl_s st_nxt;

    logic                       stop_n_sync;
    logic [`LPSPC_VID_W-1:0]    vid_now;
    logic                       vid_done;
    logic [`LPSPC_RATIO_W-1:0]  req_ratio;
    logic                       snoop_ev;
    logic                       snoop_end;
    logic                       in_snoop;
    logic                       core_run;

    ////////////////////////////////////////////////////////////////////////
    // pin synchroniser and voltage stepper
    lpspc_sync u_stop_sync (
        .CLOCK (CLOCK),
        .RST   (RST),
        .d     (STOP_CLOCK_REQUEST_N),
        .q     (stop_n_sync)
    );

    lpspc_vid_stepper u_vid (
        .CLOCK     (CLOCK),
        .RST       (RST),
        .target    (st_r.vid_tgt_r),
        .vid       (vid_now),
        .at_target (vid_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state
    // clamp to rated maximum
    assign req_ratio = (PS_RATIO > `LPSPC_RATIO_MAX) ? `LPSPC_RATIO_MAX : PS_RATIO;
    assign snoop_ev  = SNOOP_VALID || BUS_INTR;

    ////////////////////////////////////////////////////////////////////////
    // snoop end: serviced, or an interrupt latched now or on the last edge
    // an old pending interrupt does not end a later snoop
    assign snoop_end = SNOOP_DONE || BUS_INTR || st_r.intr_ev_r;

    always_comb begin
        st_nxt     = st_r;
        st_nxt.sbc_r = 1'b0;

        ////////////////////////////////////////////////////////////////////
        // performance sequence, started in normal state only
        case (st_r.ps_r)
            LPSPC_PS_IDLE: begin
                if (PS_WRITE && st_r.state_r == LPSPC_NORMAL) begin
                    st_nxt.tgt_ratio_r = req_ratio;
                    st_nxt.op_vid_r    = PS_VID;
                    st_nxt.op_ratio_r  = req_ratio;
                    if (req_ratio > st_r.ratio_r) begin
                        st_nxt.vid_tgt_r = PS_VID;
                        st_nxt.ps_r      = LPSPC_PS_UP;
                    end else begin
                        st_nxt.ratio_r = req_ratio;
                        st_nxt.ps_r    = LPSPC_PS_DOWN;
                    end
                end
            end
            LPSPC_PS_UP: begin
                if (vid_done) begin
                    st_nxt.ratio_r = st_r.tgt_ratio_r;
                    st_nxt.ps_r    = LPSPC_PS_IDLE;
                end
            end
            LPSPC_PS_DOWN: begin
                st_nxt.vid_tgt_r = st_r.op_vid_r;
                if (vid_done && st_r.vid_tgt_r == st_r.op_vid_r) begin
                    st_nxt.ps_r = LPSPC_PS_IDLE;
                end
            end
            default: begin
                st_nxt.ps_r = LPSPC_PS_IDLE;
            end
        endcase

        ////////////////////////////////////////////////////////////////////
        // power state machine
        // latch bus interrupts while stopped
        st_nxt.intr_ev_r = 1'b0;
        if (BUS_INTR && st_r.state_r != LPSPC_NORMAL) begin
            st_nxt.intr_r    = 1'b1;
            st_nxt.intr_ev_r = 1'b1;
        end

        case (st_r.state_r)
            LPSPC_NORMAL: begin
                st_nxt.intr_r = 1'b0;
                if (!stop_n_sync) begin
                    st_nxt.sbc_r   = 1'b1;
                    st_nxt.state_r = LPSPC_SG_ACK;
                end else if (HALT_REQ && st_r.ps_r == LPSPC_PS_IDLE) begin
                    if (EH_ENABLE) begin
                        st_nxt.ratio_r = `LPSPC_EH_RATIO;
                        st_nxt.state_r = LPSPC_EH_ENTER;
                    end else begin
                        st_nxt.state_r = LPSPC_HALT;
                    end
                end
            end
            LPSPC_SG_ACK: begin
                if (ACK_RESPONSE) begin
                    // the edge into waiting is the first of the count
                    st_nxt.cnt_r   = `LPSPC_GRANT_DLY - 1'b1;
                    st_nxt.state_r = LPSPC_SG_WAIT;
                end
            end
            LPSPC_SG_WAIT: begin
                st_nxt.cnt_r = st_r.cnt_r - 1'b1;
                if (st_r.cnt_r == `LPSPC_GRANT_CNT_W'(1)) begin
                    st_nxt.state_r = LPSPC_GRANT;
                end
            end
            LPSPC_GRANT: begin
                if (snoop_ev) begin
                    st_nxt.state_r = LPSPC_GR_SNOOP;
                end else if (stop_n_sync) begin
                    st_nxt.state_r = LPSPC_NORMAL;
                end
            end
            LPSPC_GR_SNOOP: begin
                if (snoop_end) begin
                    st_nxt.state_r = LPSPC_GRANT;
                end
            end
            LPSPC_HALT: begin
                if (BREAK_EVENT || st_r.intr_r) begin
                    st_nxt.state_r = LPSPC_NORMAL;
                end else if (snoop_ev) begin
                    st_nxt.state_r = LPSPC_HALT_SNOOP;
                end
            end
            LPSPC_HALT_SNOOP: begin
                if (snoop_end) begin
                    st_nxt.state_r = LPSPC_HALT;
                end
            end
            LPSPC_EH_ENTER: begin
                st_nxt.vid_tgt_r = `LPSPC_EH_VID;
                if (vid_done && st_r.vid_tgt_r == `LPSPC_EH_VID) begin
                    st_nxt.state_r = LPSPC_EH;
                end
            end
            LPSPC_EH: begin
                if (BREAK_EVENT || st_r.intr_r) begin
                    st_nxt.vid_tgt_r = st_r.op_vid_r;
                    st_nxt.state_r   = LPSPC_EH_EXIT;
                end else if (snoop_ev) begin
                    st_nxt.state_r = LPSPC_EH_SNOOP;
                end
            end
            LPSPC_EH_SNOOP: begin
                if (snoop_end) begin
                    st_nxt.state_r = LPSPC_EH;
                end
            end
            LPSPC_EH_EXIT: begin
                if (vid_done) begin
                    st_nxt.ratio_r = st_r.op_ratio_r;
                    st_nxt.state_r = LPSPC_NORMAL;
                end
            end
            default: begin
                st_nxt.state_r = LPSPC_NORMAL;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            st_r <= '{
                state_r:     LPSPC_NORMAL,
                ps_r:        LPSPC_PS_IDLE,
                ratio_r:     `LPSPC_RATIO_RST,
                op_ratio_r:  `LPSPC_RATIO_RST,
                op_vid_r:    `LPSPC_VID_RST,
                tgt_ratio_r: `LPSPC_RATIO_RST,
                vid_tgt_r:   `LPSPC_VID_RST,
                cnt_r:       '0,
                intr_r:      1'b0,
                intr_ev_r:   1'b0,
                sbc_r:       1'b0
            };
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state decode for status outputs
    always_comb begin
        in_snoop = 1'b0;
        core_run = 1'b0;
        case (st_r.state_r)
            LPSPC_NORMAL: begin
                core_run = 1'b1;
            end
            LPSPC_HALT_SNOOP: begin
                in_snoop = 1'b1;
            end
            LPSPC_EH_SNOOP: begin
                in_snoop = 1'b1;
            end
            LPSPC_GR_SNOOP: begin
                in_snoop = 1'b1;
            end
            default: begin
                in_snoop = 1'b0;
                core_run = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign SPECIAL_BUS_CYCLE_REQ = st_r.sbc_r;
    assign CORE_CLOCK_RUN        = core_run;
    assign SNOOP_ACTIVE          = in_snoop;
    assign INTR_PENDING          = st_r.intr_r;
    assign CORE_RATIO            = st_r.ratio_r;
    assign VOLTAGE_ID_CODE       = vid_now;
    assign PS_BUSY               = (st_r.ps_r != LPSPC_PS_IDLE);
    assign POWER_STATE           = st_r.state_r;
endmodule

// >>> src/lpspc_defines.svh
`ifndef LPSPC_DEFINES_SVH
`define LPSPC_DEFINES_SVH

// widths
`define LPSPC_RATIO_W        6
`define LPSPC_VID_W          8
// reset operating point
`define LPSPC_RATIO_RST      6'h10
`define LPSPC_VID_RST        8'h40
// rated maximum ratio
`define LPSPC_RATIO_MAX      6'h14
// enhanced halt operating point
`define LPSPC_EH_RATIO       6'h08
`define LPSPC_EH_VID         8'h30
// one voltage code step is 12.5 mV
`define LPSPC_VID_STEP       8'h01
// bus clocks from grant acknowledge response to clock-stopped grant
`define LPSPC_GRANT_DLY      5'h14
`define LPSPC_GRANT_CNT_W    5
// cycles a voltage code step settles before the next
`define LPSPC_SETTLE         4'h4
`define LPSPC_SETTLE_W       4

`endif

// >>> src/lpspc_pkg.sv
package lpspc_pkg;
    `include "lpspc_defines.svh"

    typedef enum logic [3:0] {
        LPSPC_NORMAL     = 4'b0000,
        LPSPC_HALT       = 4'b0001,
        LPSPC_EH_ENTER   = 4'b0010,
        LPSPC_EH         = 4'b0011,
        LPSPC_EH_EXIT    = 4'b0100,
        LPSPC_HALT_SNOOP = 4'b0101,
        LPSPC_EH_SNOOP   = 4'b0110,
        LPSPC_SG_ACK     = 4'b0111,
        LPSPC_SG_WAIT    = 4'b1000,
        LPSPC_GRANT      = 4'b1001,
        LPSPC_GR_SNOOP   = 4'b1010
    } lpspc_state_e;

    typedef enum logic [1:0] {
        LPSPC_PS_IDLE  = 2'b00,
        LPSPC_PS_UP    = 2'b01,
        LPSPC_PS_DOWN  = 2'b10
    } lpspc_ps_e;
endpackage

// >>> src/lpspc_sync.sv
module lpspc_sync
    import lpspc_pkg::*;
(
    input  wire logic CLOCK,
    input  wire logic RST,
    input  wire logic d,
    output logic      q
);
    typedef struct packed {
        logic s1_r;
        logic s2_r;
    } lpspc_sync_s;

    lpspc_sync_s st_r;
    lpspc_sync_s st_nxt;

    always_comb begin
        st_nxt.s1_r = d;
        st_nxt.s2_r = st_r.s1_r;
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            st_r <= '{s1_r: 1'b1, s2_r: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.s2_r;
endmodule

// >>> src/lpspc_vid_stepper.sv
module lpspc_vid_stepper
    import lpspc_pkg::*;
(
    input  wire logic                       CLOCK,
    input  wire logic                       RST,
    input  wire logic [`LPSPC_VID_W-1:0]    target,
    output logic      [`LPSPC_VID_W-1:0]    vid,
    output logic                            at_target
);
    typedef struct packed {
        logic [`LPSPC_VID_W-1:0]    vid_r;
        logic [`LPSPC_SETTLE_W-1:0] wait_r;
    } lpspc_vs_s;

    lpspc_vs_s st_r;
    lpspc_vs_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (st_r.wait_r != '0) begin
            st_nxt.wait_r = st_r.wait_r - 1'b1;
        end else if (target > st_r.vid_r) begin
            st_nxt.vid_r  = st_r.vid_r + `LPSPC_VID_STEP;
            st_nxt.wait_r = `LPSPC_SETTLE;
        end else if (target < st_r.vid_r) begin
            st_nxt.vid_r  = st_r.vid_r - `LPSPC_VID_STEP;
            st_nxt.wait_r = `LPSPC_SETTLE;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            st_r <= '{vid_r: `LPSPC_VID_RST, wait_r: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign vid       = st_r.vid_r;
    assign at_target = (st_r.vid_r == target) && (st_r.wait_r == '0);
endmodule

// >>> tb/lpspc_bus_agent.sv
module lpspc_bus_agent (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       sbc_req,
    input  wire logic       snoop_go,
    input  wire logic [3:0] dly,
    output logic            ack_response,
    output logic            snoop_valid,
    output logic            snoop_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] ack_cnt;
    logic [4:0] snp_cnt;
    // ack dly+1 cycles after the request, snoop held dly+1 cycles then serviced
    always @(posedge clock) begin
        ack_response <= 1'b0;
        snoop_done <= 1'b0;
        if (rst) begin
            ack_cnt <= 5'h00;
            snp_cnt <= 5'h00;
            snoop_valid <= 1'b0;
        end else begin
            if (sbc_req) begin
                ack_cnt <= {1'b0, dly} + 5'h01;
            end else if (ack_cnt != 5'h00) begin
                ack_cnt <= ack_cnt - 5'h01;
                ack_response <= (ack_cnt == 5'h01);
            end
            if (snoop_go) begin
                snoop_valid <= 1'b1;
                snp_cnt <= {1'b0, dly} + 5'h01;
            end else if (snp_cnt != 5'h00) begin
                snp_cnt <= snp_cnt - 5'h01;
                snoop_valid <= (snp_cnt != 5'h01);
                snoop_done <= (snp_cnt == 5'h01);
            end
        end
    end
endmodule

// >>> tb/lpspc_ctrl_assertions.sv
`include "lpspc_defines.svh"
module lpspc_ctrl_checker
    import lpspc_pkg::*;
(
    input wire logic                      CLOCK,
    input wire logic                      RST,
    input wire logic                      HALT_REQ,
    input wire logic                      BREAK_EVENT,
    input wire logic                      SNOOP_VALID,
    input wire logic                      SNOOP_DONE,
    input wire logic                      BUS_INTR,
    input wire logic                      ACK_RESPONSE,
    input wire logic                      PS_WRITE,
    input wire logic                      SNOOP_ACTIVE,
    input wire logic                      INTR_PENDING,
    input wire logic [`LPSPC_RATIO_W-1:0] CORE_RATIO,
    input wire logic [`LPSPC_VID_W-1:0]   VOLTAGE_ID_CODE,
    input wire logic                      PS_BUSY,
    input wire logic [3:0]                POWER_STATE
);
    logic quiet_snoop;
    assign quiet_snoop = SNOOP_VALID && !BUS_INTR && !BREAK_EVENT && !INTR_PENDING;
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RST);
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_ack_seen;
        ACK_RESPONSE && POWER_STATE == LPSPC_SG_ACK;
    endsequence
    sequence s_to_grant;
        ##19 POWER_STATE == LPSPC_SG_WAIT ##1 POWER_STATE == LPSPC_GRANT;
    endsequence
    grant_delay_a: assert property (s_ack_seen |-> s_to_grant)
        else $error("grant entry delay wrong");
    halt_snoop_a: assert property (POWER_STATE == LPSPC_HALT && quiet_snoop
        |=> POWER_STATE == LPSPC_HALT_SNOOP) else $error("halt snoop not entered");
    grant_snoop_a: assert property (POWER_STATE == LPSPC_GRANT && SNOOP_VALID
        |=> POWER_STATE == LPSPC_GR_SNOOP) else $error("grant snoop not entered");
    eh_snoop_a: assert property (POWER_STATE == LPSPC_EH && quiet_snoop
        |=> POWER_STATE == LPSPC_EH_SNOOP) else $error("eh snoop not entered");
    snoop_hold_a: assert property (SNOOP_ACTIVE && !SNOOP_DONE && !BUS_INTR
        && !$past(BUS_INTR) |=> SNOOP_ACTIVE) else $error("snoop state left early");
    snoop_return_a: assert property (POWER_STATE == LPSPC_GR_SNOOP && SNOOP_DONE
        |=> POWER_STATE == LPSPC_GRANT) else $error("no return to grant");
    eh_return_a: assert property (POWER_STATE == LPSPC_EH_SNOOP && SNOOP_DONE
        |=> POWER_STATE == LPSPC_EH) else $error("no return to eh");
    eh_point_a: assert property (POWER_STATE == LPSPC_EH_SNOOP |->
        CORE_RATIO == `LPSPC_EH_RATIO && VOLTAGE_ID_CODE == `LPSPC_EH_VID)
        else $error("eh snoop point lost");
    ratio_max_a: assert property (CORE_RATIO <= `LPSPC_RATIO_MAX)
        else $error("ratio above max");
    ps_quiet_a: assert property (POWER_STATE == LPSPC_NORMAL && !PS_BUSY && !PS_WRITE
        && !HALT_REQ |=> $stable(CORE_RATIO) && $stable(VOLTAGE_ID_CODE))
        else $error("point changed without write");
    up_order_a: assert property (CORE_RATIO > $past(CORE_RATIO) |->
        $stable(VOLTAGE_ID_CODE) ##1 $stable(VOLTAGE_ID_CODE)[*4])
        else $error("voltage moved after ratio rise");
    vid_step_a: assert property ($changed(VOLTAGE_ID_CODE) |->
        VOLTAGE_ID_CODE == $past(VOLTAGE_ID_CODE) + 8'h01
        || VOLTAGE_ID_CODE == $past(VOLTAGE_ID_CODE) - 8'h01) else $error("bad vid step");
    intr_latch_a: assert property (POWER_STATE == LPSPC_GRANT && BUS_INTR
        |=> INTR_PENDING) else $error("interrupt not latched");
endmodule
bind lpspc_ctrl lpspc_ctrl_checker u_lpspc_ctrl_checker (.CLOCK(CLOCK), .RST(RST),
    .HALT_REQ(HALT_REQ), .BREAK_EVENT(BREAK_EVENT), .SNOOP_VALID(SNOOP_VALID),
    .SNOOP_DONE(SNOOP_DONE), .BUS_INTR(BUS_INTR), .ACK_RESPONSE(ACK_RESPONSE),
    .PS_WRITE(PS_WRITE), .SNOOP_ACTIVE(SNOOP_ACTIVE), .INTR_PENDING(INTR_PENDING),
    .CORE_RATIO(CORE_RATIO), .VOLTAGE_ID_CODE(VOLTAGE_ID_CODE), .PS_BUSY(PS_BUSY),
    .POWER_STATE(POWER_STATE));

// >>> tb/lpspc_ctrl_tb_top.sv
`include "lpspc_defines.svh"
module lpspc_ctrl_tb_top;
    import lpspc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk, rst, eh_en, halt_req, brk, stop_n, bus_intr, ps_write, snoop_go;
    logic       special_bus_cycle, run, snp_act, intr_p, busy, ack, snp_v, snp_d;
    logic [5:0] ps_ratio, ratio, cur_r;
    logic [7:0] ps_vid, vid, cur_v;
    logic [3:0] st, dly;
    int         miscompares, total_checks;
    lpspc_ctrl u_lpspc_ctrl (.CLOCK(clk), .RST(rst), .EH_ENABLE(eh_en), .HALT_REQ(halt_req),
        .BREAK_EVENT(brk), .STOP_CLOCK_REQUEST_N(stop_n), .SNOOP_VALID(snp_v),
        .SNOOP_DONE(snp_d), .BUS_INTR(bus_intr), .ACK_RESPONSE(ack), .PS_WRITE(ps_write),
        .PS_RATIO(ps_ratio), .PS_VID(ps_vid), .SPECIAL_BUS_CYCLE_REQ(special_bus_cycle),
        .CORE_CLOCK_RUN(run), .SNOOP_ACTIVE(snp_act), .INTR_PENDING(intr_p),
        .CORE_RATIO(ratio), .VOLTAGE_ID_CODE(vid), .PS_BUSY(busy), .POWER_STATE(st));
    lpspc_bus_agent u_lpspc_bus_agent (.clock(clk), .rst(rst), .sbc_req(special_bus_cycle),
        .snoop_go(snoop_go), .dly(dly), .ack_response(ack), .snoop_valid(snp_v),
        .snoop_done(snp_d));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t flag %b exp %b", $time, got, exp);
        end
    endtask
    task automatic chk_op(input logic [5:0] er, input logic [7:0] ev);
        total_checks++;
        if (ratio !== er || vid !== ev) begin
            miscompares++;
            $display("[ERR] %0t point %h/%h exp %h/%h", $time, ratio, vid, er, ev);
        end
    endtask
    task automatic wait_st(input logic [3:0] s);
        int n;
        for (n = 0; n < 200; n++) begin
            @(negedge clk);
            if (st === s) break;
        end
        total_checks++;
        if (st !== s) begin
            miscompares++;
            $display("[ERR] %0t state %h exp %h", $time, st, s);
            stop_test();
        end
    endtask
    function automatic logic [5:0] exp_r(input logic [5:0] r);
        return (r > `LPSPC_RATIO_MAX) ? `LPSPC_RATIO_MAX : r;
    endfunction
    task automatic ps(input logic [5:0] r, input logic [7:0] v, input logic twice);
        int n;
        @(posedge clk);
        ps_write <= 1'b1;
        ps_ratio <= r;
        ps_vid <= v;
        @(posedge clk);
        ps_write <= twice;
        ps_ratio <= 6'h09;
        ps_vid <= 8'h31;
        @(posedge clk);
        ps_write <= 1'b0;
        for (n = 0; n < 400 && busy !== 1'b0; n++) @(negedge clk);
        cur_r = exp_r(r);
        cur_v = v;
        chk_bit(busy, 1'b0);
        if (busy !== 1'b0) stop_test();
        chk_op(cur_r, cur_v);
        repeat (6) @(negedge clk);
    endtask
    task automatic snoop(input logic [3:0] home, input logic [3:0] sn);
        @(posedge clk);
        snoop_go <= 1'b1;
        dly <= 4'($urandom_range(0, 6));
        @(posedge clk);
        snoop_go <= 1'b0;
        wait_st(sn);
        chk_bit(snp_act, 1'b1);
        wait_st(home);
    endtask
    task automatic wake;
        @(posedge clk);
        halt_req <= 1'b0;
        brk <= 1'b1;
        @(posedge clk);
        brk <= 1'b0;
        wait_st(LPSPC_NORMAL);
        repeat (8) @(negedge clk);
    endtask
    task automatic intr_pulse;
        @(posedge clk);
        bus_intr <= 1'b1;
        @(posedge clk);
        bus_intr <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst, eh_en, halt_req, brk, bus_intr, ps_write, snoop_go} = 7'h40;
        {stop_n, ps_ratio, ps_vid, dly} = {1'b1, 6'h10, 8'h40, 4'h0};
        void'($urandom(94221));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk_op(`LPSPC_RATIO_RST, `LPSPC_VID_RST);
        chk_bit(run, 1'b1);
        ps(6'h3f, 8'h50, 1'b1);
        ps(6'h09, 8'h31, 1'b0);
        repeat (6) ps(6'h08 + 6'($urandom_range(0, 23)), 8'h30 + 8'($urandom_range(0, 23)), 1'b0);
        @(posedge clk);
        halt_req <= 1'b1;
        wait_st(LPSPC_HALT);
        chk_bit(run, 1'b0);
        snoop(LPSPC_HALT, LPSPC_HALT_SNOOP);
        wake();
        @(posedge clk);
        halt_req <= 1'b1;
        wait_st(LPSPC_HALT);
        @(posedge clk);
        halt_req <= 1'b0;
        intr_pulse();
        wait_st(LPSPC_HALT_SNOOP);
        wait_st(LPSPC_HALT);
        chk_bit(intr_p, 1'b1);
        wait_st(LPSPC_NORMAL);
        repeat (8) @(negedge clk);
        @(posedge clk);
        eh_en <= 1'b1;
        halt_req <= 1'b1;
        wait_st(LPSPC_EH);
        chk_op(`LPSPC_EH_RATIO, `LPSPC_EH_VID);
        snoop(LPSPC_EH, LPSPC_EH_SNOOP);
        wake();
        chk_op(cur_r, cur_v);
        @(posedge clk);
        dly <= 4'($urandom_range(0, 6));
        stop_n <= 1'b0;
        wait_st(LPSPC_SG_ACK);
        chk_bit(special_bus_cycle, 1'b1);
        @(negedge clk);
        chk_bit(special_bus_cycle, 1'b0);
        wait_st(LPSPC_GRANT);
        snoop(LPSPC_GRANT, LPSPC_GR_SNOOP);
        intr_pulse();
        wait_st(LPSPC_GR_SNOOP);
        wait_st(LPSPC_GRANT);
        chk_bit(intr_p, 1'b1);
        @(posedge clk);
        stop_n <= 1'b1;
        wait_st(LPSPC_NORMAL);
        chk_bit(run, 1'b1);
        chk_op(cur_r, cur_v);
        stop_test();
    end
endmodule
